// File: sioenc_top.sv
// Servo drive digital I/O front end: target selection, start, limits,
// enable/error clear, ready/brake, incremental input and emulated output.
// Assumes all inputs are already synchronous to clk_i and debounced outside.
`timescale 1ns/100ps
`default_nettype none
module sioenc_top (
  input  wire logic                 clk_i,                   // 200 MHz clock
  input  wire logic                 reset_n_i,               // Async reset, active low
  input  wire logic                 target_sel_bit0_i,       // Pin, shared with analogue 0
  input  wire logic                 target_sel_bit1_i,       // Pin, shared with analogue 0
  input  wire logic                 target_sel_bit2_i,       // Pin, shared with analogue 1
  input  wire logic                 target_sel_bit3_i,       // Pin, shared with analogue 1
  input  wire logic                 group_sel_bit0_or_enc_a_i, // Group bit 0 or A
  input  wire logic                 group_sel_bit1_or_enc_b_i, // Group bit 1 or B
  input  wire logic                 start_pos_or_enc_index_i,  // Start or index
  input  wire logic                 limit_switch_0_i,        // Travel limit 0
  input  wire logic                 limit_switch_1_i,        // Travel limit 1
  input  wire logic                 drive_enable_err_clear_i,// Enable / clear on fall
  input  wire logic [1:0]           in_mode_i,               // Input mode select
  input  wire logic [2:0]           in_lines_i,              // Input line count code
  input  wire logic [2:0]           out_lines_i,             // Emulation line count code
  input  wire logic                 emul_en_i,               // General outputs carry A/B
  input  wire logic                 gp_out_a_cfg_i,          // Free value of general out A
  input  wire logic                 gp_out_b_cfg_i,          // Free value of general out B
  input  wire logic                 analog0_sel_i,           // Analogue 0 uses its pins
  input  wire logic                 analog1_sel_i,           // Analogue 1 uses its pins
  input  wire logic [11:0]          setpoint_analog_0_i,     // Converted setpoint 0
  input  wire logic [11:0]          setpoint_analog_1_i,     // Converted setpoint 1
  input  wire logic [15:0]          rotor_angle_i,           // Measured rotor angle
  input  wire logic                 fault_i,                 // Drive fault event
  input  wire logic                 brake_release_i,         // Control asks brake operated
  input  wire logic [7:0]           monitor_value_i,         // Value for monitor converter
  output logic                      ready_out_o,             // Operational / ready
  output logic                      gp_out_a_emul_o,         // General output A
  output logic                      gp_out_b_emul_o,         // General output B
  output logic                      brake_out_o,             // Holding brake drive
  output logic [7:0]                monitor_analog_out_o,    // Monitor converter word
  output logic [3:0]                target_index_o,          // Latched target index
  output logic [1:0]                group_index_o,           // Latched group index
  output logic                      start_pulse_o,           // One-cycle run launch
  output logic                      limit_0_o,               // Limit 0 asserted
  output logic                      limit_1_o,               // Limit 1 asserted
  output logic                      error_o,                 // Pending error flag
  output logic [15:0]               follow_pos_o,            // Follower position count
  output logic                      index_seen_o,            // One-cycle index pulse
  output logic [11:0]               setpoint_0_o,            // Registered setpoint 0
  output logic [11:0]               setpoint_1_o,            // Registered setpoint 1
  output logic                      setpoint_0_vld_o,        // Setpoint 0 in use
  output logic                      setpoint_1_vld_o         // Setpoint 1 in use
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_r;                                    // Release shift pair
  logic       rst_n;                                         // Synchronised reset

  // Assert at once, release after two edges
  // Release is timed to the clock so no flop sees reset lift near its edge;
  // entry stays asynchronous so outputs drop even with the clock stopped
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  // Only the second flop is read; the first may still be settling
  assign rst_n = rst_sync_r[1];

  // ****************************************
  // Input decoding
  // ****************************************
  logic [5:0] sel_word;                                      // Six-bit selection, shared pins masked
  logic       enc_mode;                                      // Pins act as encoder
  logic       start_lvl;                                     // Start as logic input
  logic       start_d_r;                                     // Previous start level
  logic       en_d_r;                                        // Previous enable level

  // High level means asserted; no inversion anywhere
  // Pins lent to an analogue input read as zero, so a stale level on a
  // shared pin can never leak into the latched target index
  assign sel_word = {group_sel_bit1_or_enc_b_i, group_sel_bit0_or_enc_a_i,
                     target_sel_bit3_i & ~analog1_sel_i, target_sel_bit2_i & ~analog1_sel_i,
                     target_sel_bit1_i & ~analog0_sel_i, target_sel_bit0_i & ~analog0_sel_i};
  // Encoder modes take the group and start pins away
  assign enc_mode  = (in_mode_i != sioenc_pkg::SIOENC_IN_LOGIC);
  assign start_lvl = start_pos_or_enc_index_i & ~enc_mode;

  // Edge history for start and enable
  // Both histories reset low: a start pin already high at release gives a
  // start edge, but an enable held high gives no false clear
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_d_r <= 1'b0;
      en_d_r    <= 1'b0;
    end else begin
      start_d_r <= start_lvl;
      en_d_r    <= drive_enable_err_clear_i;
    end
  end

  // ****************************************
  // Selection latch and start
  // ****************************************
  // Sampled on the rising start edge so a moving selection cannot disturb a run
  // Group bits keep their old value while their pins carry encoder signals
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      target_index_o <= sioenc_pkg::RST_SEL[3:0];
      group_index_o  <= sioenc_pkg::RST_SEL[5:4];
      start_pulse_o  <= 1'b0;
    end else begin
      start_pulse_o <= start_lvl & ~start_d_r;
      if (start_lvl && !start_d_r) begin
        target_index_o <= sel_word[sioenc_pkg::SEL_TGT_LSB +: 4];
        if (!enc_mode) begin
          group_index_o <= sel_word[sioenc_pkg::SEL_GRP_LSB +: 2];
        end
      end
    end
  end

  // ****************************************
  // Limits, enable, error, ready, brake
  // ****************************************
  logic en_fall;                                             // Enable high-to-low
  // Falling enable seen against last cycle's level
  assign en_fall = en_d_r & ~drive_enable_err_clear_i;

  // Error: a fault in the clearing cycle wins over the clear
  // Set beats clear so a fault arriving while the operator clears is kept;
  // the operator must lower the enable once more after the fault has gone
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      error_o <= 1'b0;
    end else if (fault_i) begin
      error_o <= 1'b1;
    end else if (en_fall) begin
      error_o <= 1'b0;
    end
  end

  // Status outputs, all registered
  // Limits pass through one flop only; debouncing is left to the far side
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      limit_0_o   <= 1'b0;
      limit_1_o   <= 1'b0;
      ready_out_o <= 1'b0;
      brake_out_o <= 1'b0;
    end else begin
      limit_0_o   <= limit_switch_0_i;
      limit_1_o   <= limit_switch_1_i;
      // Ready needs enable, no error and no fault; drops in the same cycle as the error flag
      ready_out_o <= drive_enable_err_clear_i & ~error_o & ~fault_i;
      // Brake operated only while enabled with no error flag and control asks it; fault_i itself is not gated
      brake_out_o <= brake_release_i & drive_enable_err_clear_i & ~error_o;
    end
  end

  // ****************************************
  // Incremental follower input
  // ****************************************
  logic       a_d_r;                                         // Previous A
  logic       b_d_r;                                         // Previous B
  logic       n_d_r;                                         // Previous index
  logic       a_in;
  logic       b_in;
  logic       n_in;
  logic [1:0] step;                                          // 01 up, 11 down, else none
  logic [15:0] pos_nxt;

  assign a_in = group_sel_bit0_or_enc_a_i;
  assign b_in = group_sel_bit1_or_enc_b_i;
  assign n_in = start_pos_or_enc_index_i;

  // Edge history of the encoder pins
  // Reset low: a pin resting high at reset release in quadrature use costs one count
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
      n_d_r <= 1'b0;
    end else begin
      a_d_r <= a_in;
      b_d_r <= b_in;
      n_d_r <= n_in;
    end
  end

  // Step decode; a double transition is a lost count and is ignored
  // Limitation: inputs must move at most one phase per clock, far above any
  // real line rate, or counts are dropped without notice
  always_comb begin
    step = 2'h0;
    if (in_mode_i == sioenc_pkg::SIOENC_IN_QUAD) begin
      if ((a_in ^ a_d_r) && !(b_in ^ b_d_r)) begin
        step = (a_in ^ b_in) ? 2'h1 : 2'h3;
      end else if ((b_in ^ b_d_r) && !(a_in ^ a_d_r)) begin
        step = (a_in ^ b_in) ? 2'h3 : 2'h1;
      end
    end else if (in_mode_i == sioenc_pkg::SIOENC_IN_PDIR) begin
      if (a_in && !a_d_r) begin
        step = b_in ? 2'h3 : 2'h1;
      end
    end
  end

  // Count in fine steps, then scale: counts per turn are 4 x lines in quadrature
  // Pulse/direction gives one count per pulse, so a turn takes 4 x lines pulses
  assign pos_nxt = (step == 2'h1) ? follow_pos_o + 16'h0001 :
                   (step == 2'h3) ? follow_pos_o - 16'h0001 : follow_pos_o;

  // Position wraps per turn at 4 x the programmed line count; index re-zeroes it
  // Index only acts in quadrature use; in pulse/direction use the same pin
  // is neither start nor index and is simply ignored
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      follow_pos_o <= sioenc_pkg::RST_POS;
      index_seen_o <= 1'b0;
    end else begin
      index_seen_o <= (in_mode_i == sioenc_pkg::SIOENC_IN_QUAD) & n_in & ~n_d_r;
      if ((in_mode_i == sioenc_pkg::SIOENC_IN_QUAD) && n_in && !n_d_r) begin
        follow_pos_o <= sioenc_pkg::RST_POS;
      end else begin
        follow_pos_o <= pos_nxt & ((16'h0080 << in_lines_i) - 16'h0001);
      end
    end
  end

  // ****************************************
  // Encoder emulation output
  // ****************************************
  logic [11:0] emu_cnt;                                      // Quarter-line count of angle
  logic [1:0]  emu_phase;                                    // Gray phase: A then B
  logic [3:0]  emu_shift;                                    // Angle bits below a quarter line

  // Shift is worked out at four bits; a three-bit sum would wrap and pick wrong bits
  assign emu_shift = 4'(sioenc_pkg::ANGLE_W - 2 - sioenc_pkg::LINES_MIN_LOG2) - {1'b0, out_lines_i};
  // Angle top bits give 4 x lines positions per turn
  assign emu_cnt   = 12'(rotor_angle_i >> emu_shift);
  // Phase sequence 00,10,11,01 means A leads B for rising angle
  assign emu_phase = {emu_cnt[1] ^ emu_cnt[0], emu_cnt[1]};

  // General outputs: free value or emulated A/B, index not produced
  // Switching the source takes effect on the next edge; a clean hand over is
  // left to whoever flips emul_en_i while the shaft is moving
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gp_out_a_emul_o <= 1'b0;
      gp_out_b_emul_o <= 1'b0;
    end else if (emul_en_i) begin
      gp_out_a_emul_o <= emu_phase[1];
      gp_out_b_emul_o <= emu_phase[0];
    end else begin
      gp_out_a_emul_o <= gp_out_a_cfg_i;
      gp_out_b_emul_o <= gp_out_b_cfg_i;
    end
  end

  // ****************************************
  // Analogue setpoints and monitor
  // ****************************************
  // Setpoints only valid while their pins are given to analogue use
  // Values are passed every cycle; the valid flags tell the loop when to
  // trust them, which saves a second mux on the twelve-bit paths
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_0_o         <= 12'h000;
      setpoint_1_o         <= 12'h000;
      setpoint_0_vld_o     <= 1'b0;
      setpoint_1_vld_o     <= 1'b0;
      monitor_analog_out_o <= 8'h00;
    end else begin
      setpoint_0_o         <= setpoint_analog_0_i;
      setpoint_1_o         <= setpoint_analog_1_i;
      setpoint_0_vld_o     <= analog0_sel_i;
      setpoint_1_vld_o     <= analog1_sel_i;
      monitor_analog_out_o <= monitor_value_i;
    end
  end

endmodule
`default_nettype wire

// File: sioenc_pkg.sv
// Package for the servo target select and incremental I/O front end.
// Assumes a single 200 MHz clock domain; nothing is imported, use sioenc_pkg::name.
`default_nettype none
package sioenc_pkg;
  // ****************************************
  // Clock and widths
  // ****************************************
  localparam int unsigned CLK_MHZ      = 200;           // System clock rate
  localparam int unsigned TARGET_W     = 4;             // Target index width
  localparam int unsigned GROUP_W      = 2;             // Group index width
  localparam int unsigned ADC_W        = 12;            // Analogue setpoint width
  localparam int unsigned MON_W        = 8;             // Monitor converter width
  localparam int unsigned POS_W        = 16;            // Position counter width
  localparam int unsigned ANGLE_W      = 16;            // Rotor angle width
  // ****************************************
  // Field positions in the six-bit selection word
  // ****************************************
  localparam int unsigned SEL_TGT_LSB  = 0;             // Target bits 0..3
  localparam int unsigned SEL_GRP_LSB  = 4;             // Group bits 4..5
  // ****************************************
  // Line count codes: 32 << code, code 0..5
  // ****************************************
  localparam logic [2:0]  LINES_32     = 3'h0;          // 32 lines per turn
  localparam logic [2:0]  LINES_1024   = 3'h5;          // 1024 lines per turn
  localparam int unsigned LINES_MIN_LOG2 = 5;           // log2 of 32
  // ****************************************
  // Input mode select
  // ****************************************
  typedef enum logic [1:0] {
    SIOENC_IN_LOGIC = 2'h0,                             // Positioning functions
    SIOENC_IN_QUAD  = 2'h1,                             // A/B/N quadrature
    SIOENC_IN_PDIR  = 2'h2                              // Pulse and direction
  } sioenc_in_mode_t;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_POS      = 16'h0000;      // Follower position
  localparam logic [5:0]  RST_SEL      = 6'h00;         // Latched selection
endpackage
`default_nettype wire

// File: sioenc_checker.sv
// Checker for the servo I/O front end, bound to sioenc_top.
// Assumes one clock; checks start once the reset synchroniser has let go.
`timescale 1ns/100ps
`default_nettype none
module sioenc_checker (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       target_sel_bit0_i,
  input wire logic       target_sel_bit1_i,
  input wire logic       target_sel_bit2_i,
  input wire logic       target_sel_bit3_i,
  input wire logic       group_sel_bit0_or_enc_a_i,
  input wire logic       group_sel_bit1_or_enc_b_i,
  input wire logic       start_pos_or_enc_index_i,
  input wire logic       limit_switch_0_i,
  input wire logic       limit_switch_1_i,
  input wire logic       drive_enable_err_clear_i,
  input wire logic [1:0] in_mode_i,
  input wire logic       analog0_sel_i,
  input wire logic       analog1_sel_i,
  input wire logic       fault_i,
  input wire logic       brake_release_i,
  input wire logic       ready_out_o,
  input wire logic       brake_out_o,
  input wire logic [3:0] target_index_o,
  input wire logic [1:0] group_index_o,
  input wire logic       start_pulse_o,
  input wire logic       limit_0_o,
  input wire logic       limit_1_o,
  input wire logic       error_o
);
  logic [2:0] live_cnt_r; // Edges since reset release
  logic [3:0] exp_tgt;    // Target pins after analogue masking
  // Wait out the two-flop release, plus two margin edges
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      live_cnt_r <= 3'h0;
    end else if (live_cnt_r != 3'h4) begin
      live_cnt_r <= live_cnt_r + 3'h1;
    end
  end
  // Shared pins read as zero while their analogue input owns them
  assign exp_tgt = {{2{!analog1_sel_i}} & {target_sel_bit3_i, target_sel_bit2_i},
                    {2{!analog0_sel_i}} & {target_sel_bit1_i, target_sel_bit0_i}};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || live_cnt_r != 3'h4);
  // A start request: rising start level in positioning mode
  sequence start_taken_s;
    start_pos_or_enc_index_i && !$past(start_pos_or_enc_index_i) && (in_mode_i == sioenc_pkg::SIOENC_IN_LOGIC);
  endsequence
  start_launch_a: assert property (start_taken_s |=> start_pulse_o)
    else $error("start not launched");
  pulse_width_a: assert property (start_pulse_o |=> !start_pulse_o)
    else $error("start pulse longer than one cycle");
  target_latch_a: assert property (start_taken_s |=> target_index_o == $past(exp_tgt))
    else $error("target index wrong");
  group_latch_a: assert property (start_taken_s |=>
    group_index_o == $past({group_sel_bit1_or_enc_b_i, group_sel_bit0_or_enc_a_i})) else $error("group index wrong");
  select_hold_a: assert property (!start_pulse_o |-> $stable(target_index_o) && $stable(group_index_o))
    else $error("selection changed without start");
  start_refused_a: assert property (in_mode_i != sioenc_pkg::SIOENC_IN_LOGIC |=> !start_pulse_o)
    else $error("start taken in encoder mode");
  fault_sets_a: assert property (fault_i |=> error_o ##1 (error_o || $past(!drive_enable_err_clear_i)))
    else $error("fault did not set error");
  error_clear_a: assert property ($fell(drive_enable_err_clear_i) && !fault_i |=> !error_o)
    else $error("enable fall did not clear error");
  ready_state_a: assert property (ready_out_o == $past(drive_enable_err_clear_i && !error_o && !fault_i))
    else $error("ready level wrong");
  brake_drive_a: assert property (brake_out_o |-> $past(brake_release_i && drive_enable_err_clear_i && !error_o))
    else $error("brake operated while not allowed");
  limit_follow_a: assert property ({limit_1_o, limit_0_o} == $past({limit_switch_1_i, limit_switch_0_i}))
    else $error("limit output wrong");
endmodule
bind sioenc_top sioenc_checker i_chk (.*);
`default_nettype wire

// File: sioenc_plc_model.sv
// Far-side controller model: drives the two shared group/encoder pins.
// Assumes the bench steps it at most once every two clock cycles.
`timescale 1ns/100ps
`default_nettype none
module sioenc_plc_model (
  input  wire logic       clk_i,   // Bench clock
  input  wire logic [1:0] mode_i,  // Pin use, same codes as the drive
  input  wire logic [1:0] grp_i,   // Group index in positioning use
  input  wire logic       step_i,  // One step per high cycle
  input  wire logic       dn_i,    // Step direction, high counts down
  output logic            enc_a_o, // Group bit 0 or A
  output logic            enc_b_o  // Group bit 1 or B
);
  logic [1:0] phase_r = 2'h0; // Quadrature phase
  logic       pulse_r = 1'b0; // Pulse line level
  // One pin moves per step, so the far side never skips a phase
  always @(posedge clk_i) begin
    if (step_i) begin
      phase_r <= dn_i ? phase_r - 2'h1 : phase_r + 2'h1;
      pulse_r <= !pulse_r;
    end
  end
  // Pin use follows the mode the drive is set to
  always_comb begin
    if (mode_i == sioenc_pkg::SIOENC_IN_QUAD) begin
      enc_a_o = phase_r[1] ^ phase_r[0];
      enc_b_o = phase_r[1];
    end else if (mode_i == sioenc_pkg::SIOENC_IN_PDIR) begin
      enc_a_o = pulse_r;
      enc_b_o = dn_i;
    end else begin
      {enc_b_o, enc_a_o} = grp_i;
    end
  end
endmodule
`default_nettype wire

// File: servo_io_target_select_encoder_io_test.sv
// Self-checking bench for sioenc_top with a controller model on shared pins.
// Assumes outputs settle one cycle after each sampling edge.
`timescale 1ns/100ps
`default_nettype none
module servo_io_target_select_encoder_io_test;
  logic clk_i = 1'b0, reset_n_i = 1'b0;
  logic target_sel_bit0_i, target_sel_bit1_i, target_sel_bit2_i, target_sel_bit3_i;
  logic group_sel_bit0_or_enc_a_i, group_sel_bit1_or_enc_b_i, start_pos_or_enc_index_i;
  logic limit_switch_0_i, limit_switch_1_i, drive_enable_err_clear_i, fault_i, brake_release_i;
  logic emul_en_i, gp_out_a_cfg_i, gp_out_b_cfg_i, analog0_sel_i, analog1_sel_i, plc_step, plc_dn;
  logic [1:0] in_mode_i, group_index_o, plc_grp;
  logic [2:0] in_lines_i, out_lines_i;
  logic [11:0] setpoint_analog_0_i, setpoint_analog_1_i, setpoint_0_o, setpoint_1_o;
  logic [15:0] rotor_angle_i, follow_pos_o, base;
  logic [7:0] monitor_value_i, monitor_analog_out_o;
  logic [3:0] target_index_o;
  logic ready_out_o, gp_out_a_emul_o, gp_out_b_emul_o, brake_out_o, start_pulse_o, limit_0_o;
  logic limit_1_o, error_o, index_seen_o, setpoint_0_vld_o, setpoint_1_vld_o;
  int num_errors = 0;
  int comparisons = 0;
  sioenc_top i_dut (.*);
  sioenc_plc_model i_plc (.clk_i(clk_i), .mode_i(in_mode_i), .grp_i(plc_grp), .step_i(plc_step),
    .dn_i(plc_dn), .enc_a_o(group_sel_bit0_or_enc_a_i), .enc_b_o(group_sel_bit1_or_enc_b_i));
  always #2.5 clk_i = ~clk_i;
  // Inputs move 1 ns after the edge, never on it
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Set selection, then one start (or index) pulse with a low cycle after
  task automatic run(input logic [3:0] t, input logic [1:0] g, input logic go);
    {target_sel_bit3_i, target_sel_bit2_i, target_sel_bit1_i, target_sel_bit0_i} = t;
    plc_grp = g;
    tick();
    start_pos_or_enc_index_i = 1'b1;
    tick();
    chk(16'(start_pulse_o), 16'(go));
    chk(16'(index_seen_o), 16'(in_mode_i == sioenc_pkg::SIOENC_IN_QUAD));
    start_pos_or_enc_index_i = 1'b0;
    tick();
  endtask
  // Encoder steps two cycles apart so a pin moves at most every other cycle
  task automatic step(input logic dn, input int n);
    plc_dn = dn;
    repeat (n) begin
      plc_step = 1'b1;
      tick();
      plc_step = 1'b0;
      tick();
    end
    tick(2);
  endtask
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {target_sel_bit0_i, target_sel_bit1_i, target_sel_bit2_i, target_sel_bit3_i, start_pos_or_enc_index_i,
     limit_switch_0_i, limit_switch_1_i, drive_enable_err_clear_i, fault_i, brake_release_i, emul_en_i,
     gp_out_a_cfg_i, gp_out_b_cfg_i, analog0_sel_i, analog1_sel_i, plc_step, plc_dn, in_mode_i, plc_grp,
     in_lines_i, out_lines_i, setpoint_analog_0_i, setpoint_analog_1_i, rotor_angle_i, monitor_value_i} = '0;
    repeat (16) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    tick(3);
    // Every target and group, starts three cycles apart
    for (int k = 0; k < 16; k++) begin
      run(4'(k), 2'(k >> 2), 1'b1);
      chk(16'(target_index_o), 16'(k));
      chk(16'(group_index_o), 16'(k >> 2));
    end
    in_mode_i = sioenc_pkg::SIOENC_IN_PDIR;
    run(4'h0, 2'h0, 1'b0);
    chk(16'({target_index_o, group_index_o}), 16'h003f);
    in_mode_i = sioenc_pkg::SIOENC_IN_LOGIC;
    {analog1_sel_i, analog0_sel_i} = 2'h1;
    setpoint_analog_0_i = 12'ha5c;
    setpoint_analog_1_i = 12'h3f1;
    run(4'hf, 2'h1, 1'b1);
    chk(16'(target_index_o), 16'h000c);
    chk(16'({setpoint_0_vld_o, setpoint_1_vld_o}), 16'h0002);
    chk(16'(setpoint_0_o), 16'h0a5c);
    {analog1_sel_i, analog0_sel_i} = 2'h2;
    run(4'hf, 2'h1, 1'b1);
    chk(16'(target_index_o), 16'h0003);
    chk(16'(setpoint_1_o), 16'h03f1);
    {analog1_sel_i, analog0_sel_i} = 2'h0;
    // Encoder use: start refused, index zeroes the follower
    in_mode_i = sioenc_pkg::SIOENC_IN_QUAD;
    run(4'h0, 2'h0, 1'b0);
    chk(16'({target_index_o, group_index_o}), 16'h000d);
    tick(2);
    chk(follow_pos_o, 16'h0000);
    step(1'b0, 5);
    chk(follow_pos_o, 16'h0005);
    step(1'b1, 6);
    chk(follow_pos_o, 16'h007f);
    in_lines_i = 3'h5;
    run(4'h0, 2'h0, 1'b0);
    step(1'b1, 1);
    chk(follow_pos_o, 16'h0fff);
    in_mode_i = sioenc_pkg::SIOENC_IN_PDIR;
    tick(4);
    base = follow_pos_o;
    step(1'b0, 4);
    chk(follow_pos_o, (base + 16'h0002) & 16'h0fff);
    step(1'b1, 4);
    chk(follow_pos_o, base);
    in_mode_i = sioenc_pkg::SIOENC_IN_LOGIC;
    // Fault, then clear by enable falling; set wins over clear
    drive_enable_err_clear_i = 1'b1;
    brake_release_i = 1'b1;
    tick(2);
    chk(16'({ready_out_o, brake_out_o, error_o}), 16'h0006);
    fault_i = 1'b1;
    tick();
    drive_enable_err_clear_i = 1'b0;
    tick();
    fault_i = 1'b0;
    tick();
    chk(16'({ready_out_o, brake_out_o, error_o}), 16'h0001);
    drive_enable_err_clear_i = 1'b1;
    tick();
    drive_enable_err_clear_i = 1'b0;
    tick();
    chk(16'(error_o), 16'h0000);
    drive_enable_err_clear_i = 1'b1;
    tick(2);
    chk(16'({ready_out_o, brake_out_o, error_o}), 16'h0006);
    // Limits, free outputs and monitor word
    for (int k = 0; k < 4; k++) begin
      {limit_switch_1_i, limit_switch_0_i, gp_out_a_cfg_i, gp_out_b_cfg_i} = 4'(k * 5);
      monitor_value_i = 8'(k * 85);
      tick(2);
      chk(16'({limit_1_o, limit_0_o}), 16'(k));
      chk(16'({gp_out_a_emul_o, gp_out_b_emul_o}), 16'(k));
      chk(16'(monitor_analog_out_o), 16'(k * 85));
    end
    // Emulated A/B: low angle bits set so a wrong shift shows
    emul_en_i = 1'b1;
    for (int c = 0; c < 6; c++) begin
      for (int p = 0; p < 4; p++) begin
        out_lines_i = 3'(c);
        rotor_angle_i = 16'((p << (9 - c)) | ((1 << (9 - c)) - 1));
        tick(3);
        chk(16'({gp_out_a_emul_o, gp_out_b_emul_o}), 16'({p[1] ^ p[0], p[1]}));
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
